// ===== hdl/spc_pkg.sv
// Package with register map, field positions and timing for suspend pin conditioning.
package spc_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] FC1_IDX   = 8'ha0;
	localparam logic [7:0] FC3_IDX   = 8'had;
	localparam logic [7:0] RC1_IDX   = 8'hd4;
	localparam logic [7:0] RC2_IDX   = 8'hd5;
	localparam logic [7:0] PMU5_IDX  = 8'h50;
	localparam logic [7:0] PMU11_IDX = 8'h79;

	// Reset values.
	localparam logic [7:0] FC1_RST   = 8'h00;
	localparam logic [7:0] FC3_RST   = 8'h00;
	localparam logic [7:0] RC1_RST   = 8'h00;
	localparam logic [7:0] RC2_RST   = 8'h00;
	localparam logic [7:0] PMU5_RST  = 8'h00;
	localparam logic [7:0] PMU11_RST = 8'h00;

	// Field positions.
	localparam int FC1_AUTO_BIT  = 6;
	localparam int FC3_ZV_BIT    = 5;
	localparam int FC3_SRST_BIT  = 3;
	localparam int RC1_ADDR_LSB  = 6;
	localparam int RC1_DATA_LSB  = 4;
	localparam int RC1_CTRL_LSB  = 2;
	localparam int RC2_DACK_LSB  = 6;
	localparam int RC2_FPE_BIT   = 5;
	localparam int PMU5_PERI_BIT = 4;
	localparam int PMU11_KB_BIT  = 0;

	// Pull-down field codes.
	localparam logic [1:0] PD_AUTO   = 2'h0;
	localparam logic [1:0] PD_ALWAYS = 2'h1;
	localparam logic [1:0] PD_NEVER  = 2'h2;

	// Suspend state codes for the decode lines.
	localparam logic [1:0] DACK_PULL_LOW = 2'h0;
	localparam logic [1:0] DACK_TRISTATE = 2'h1;

	// Timing.
	localparam int CLK_PERIOD_NS = 5;
	localparam int RESUME_RST_NS = 1000;
	localparam int RESUME_RST_CYC = (RESUME_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Matches a byte address against a register index.
	function automatic logic spc_hit(input logic [9:0] addr, input logic [7:0] idx);
		spc_hit = (addr == {idx, 2'h0});
	endfunction : spc_hit

endpackage : spc_pkg

// ===== hdl/spc_resume_pulse.sv
// Fixed-length pulse generator used for the processor resets on resume.
`timescale 1ns/10ps
module spc_resume_pulse #(
	parameter int CYCLES = spc_pkg::RESUME_RST_CYC
) (
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// Trigger and pulse.
	input  wire logic fire,
	output logic      busy
);
	import spc_pkg::*;

	typedef struct packed {
		logic [15:0] count;
		logic        busy;
	} spc_pulse_t;

	spc_pulse_t s;
	spc_pulse_t next_s;

	always_comb begin
		next_s = s;
		if (fire) begin
			next_s.count = 16'(CYCLES - 1);
			next_s.busy  = 1'b1;
		end else if (s.busy) begin
			if (s.count == 16'h0000) begin
				next_s.busy = 1'b0;
			end else begin
				next_s.count = s.count - 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign busy = s.busy;

endmodule : spc_resume_pulse

// ===== hdl/spc_top.sv
// Suspend pin conditioning: keeper pull-downs, zero-volt suspend and clock gating.
`timescale 1ns/10ps
module spc_top #(
	parameter int HIGH_W = 4,
	parameter int RST_CYCLES = spc_pkg::RESUME_RST_CYC
) (
	// Clock and reset.
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// Avalon-MM register slave.
	input  wire logic [9:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic [31:0]               avs_readdata,
	output logic                      avs_waitrequest,
	// System power state.
	input  wire logic                 bus_hold,
	input  wire logic                 suspend_active,
	// Processor line keeper pull-downs.
	output logic                      addr_pulldown_en,
	output logic                      data_pulldown_en,
	output logic                      cycle_pulldown_en,
	// Floating-point error pin resistors.
	output logic                      float_error_pin_pullup_en,
	output logic                      float_error_pin_pulldown_en,
	// Decode lines toward the expansion side.
	input  wire logic [2:0]           dma_ack_decode_in,
	output logic [2:0]                dma_ack_decode_lines,
	output logic [2:0]                dma_ack_decode_lines_oe,
	output logic [2:0]                dma_ack_decode_lines_pd,
	// Processor outputs that idle high in suspend.
	input  wire logic [HIGH_W-1:0]    cpu_high_in,
	output logic [HIGH_W-1:0]         cpu_high_out,
	output logic [HIGH_W-1:0]         cpu_high_oe,
	// Processor resets.
	input  wire logic                 soft_reset_req,
	input  wire logic                 hard_reset_req,
	output logic                      soft_cpu_reset_out,
	output logic                      cpu_hard_reset_out,
	// Clocks.
	input  wire logic                 fourteen_mhz_oscillator,
	output logic                      periph_clock_out,
	output logic                      keyboard_clock_out,
	output logic                      keyboard_clock_out_two
);
	import spc_pkg::*;

	typedef struct packed {
		logic                bus_ack;
		logic [7:0]          rdata;
		logic [7:0]          fc1;
		logic [7:0]          fc3;
		logic [7:0]          rc1;
		logic [7:0]          rc2;
		logic [7:0]          pmu5;
		logic [7:0]          pmu11;
		logic                addr_pd;
		logic                data_pd;
		logic                cyc_pd;
		logic                fpe_pu;
		logic                fpe_pd;
		logic [2:0]          dack;
		logic [2:0]          dack_oe;
		logic [2:0]          dack_pd;
		logic [HIGH_W-1:0]   high;
		logic [HIGH_W-1:0]   high_oe;
		logic                susp_d;
		logic                soft_rst;
		logic                hard_rst;
		logic                periph_clk;
		logic                kb_clk;
	} spc_state_t;

	spc_state_t s;
	spc_state_t next_s;

	logic bus_req;
	logic resume_fire;
	logic rst_pulse;
	logic auto_window;

	// Pull-down decision shared by the three line groups.
	function automatic logic pd_sel(input logic [1:0] field, input logic auto_on);
		logic r;
		r = 1'b0;
		case (field)
			PD_AUTO:   r = auto_on;
			PD_ALWAYS: r = 1'b1;
			default:   r = 1'b0;
		endcase
		return r;
	endfunction : pd_sel

	// Register read mux; unmapped addresses read as zero.
	function automatic logic [7:0] rd_mux(input logic [9:0] a, input spc_state_t st);
		logic [7:0] v;
		v = 8'h00;
		if (spc_hit(a, FC1_IDX)) begin
			v = st.fc1;
		end else if (spc_hit(a, FC3_IDX)) begin
			v = st.fc3;
		end else if (spc_hit(a, RC1_IDX)) begin
			v = st.rc1;
		end else if (spc_hit(a, RC2_IDX)) begin
			v = st.rc2;
		end else if (spc_hit(a, PMU5_IDX)) begin
			v = st.pmu5;
		end else if (spc_hit(a, PMU11_IDX)) begin
			v = st.pmu11;
		end
		return v;
	endfunction : rd_mux

	assign bus_req     = avs_read | avs_write;
	assign resume_fire = s.susp_d & ~suspend_active;
	assign auto_window = s.fc1[FC1_AUTO_BIT] & (bus_hold | suspend_active);

	// One wait cycle per access keeps the read mux off the combinational bus path.
	assign avs_waitrequest = bus_req & ~s.bus_ack;

	spc_resume_pulse #(
		.CYCLES (RST_CYCLES)
	) u_pulse (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.fire    (resume_fire),
		.busy    (rst_pulse)
	);

	always_comb begin
		next_s = s;
		// Bus slave.
		next_s.bus_ack = bus_req & ~s.bus_ack;
		if (bus_req && !s.bus_ack) begin
			next_s.rdata = rd_mux(avs_address, s);
		end
		if (avs_write && s.bus_ack && avs_byteenable[0]) begin
			if (spc_hit(avs_address, FC1_IDX)) begin
				next_s.fc1 = avs_writedata[7:0];
			end else if (spc_hit(avs_address, FC3_IDX)) begin
				next_s.fc3 = avs_writedata[7:0];
			end else if (spc_hit(avs_address, RC1_IDX)) begin
				next_s.rc1 = avs_writedata[7:0];
			end else if (spc_hit(avs_address, RC2_IDX)) begin
				next_s.rc2 = avs_writedata[7:0];
			end else if (spc_hit(avs_address, PMU5_IDX)) begin
				next_s.pmu5 = avs_writedata[7:0];
			end else if (spc_hit(avs_address, PMU11_IDX)) begin
				next_s.pmu11 = avs_writedata[7:0];
			end
		end

		// Keeper pull-downs; the cycle-type lines idle low, which reads as inactive.
		next_s.addr_pd = pd_sel(s.rc1[RC1_ADDR_LSB+:2], auto_window);
		next_s.data_pd = pd_sel(s.rc1[RC1_DATA_LSB+:2], auto_window);
		next_s.cyc_pd  = pd_sel(s.rc1[RC1_CTRL_LSB+:2], auto_window);

		// Float error pin: in auto mode pull-up while running, pull-down in suspend; else pull-up unless the RC2 bit is set.
		if (s.fc1[FC1_AUTO_BIT]) begin
			next_s.fpe_pu = ~suspend_active;
			next_s.fpe_pd = suspend_active;
		end else begin
			next_s.fpe_pu = ~s.rc2[RC2_FPE_BIT];
			next_s.fpe_pd = 1'b0;
		end

		// Decode lines: pass through when running, parked per field in suspend.
		next_s.dack    = dma_ack_decode_in;
		next_s.dack_oe = 3'h7;
		next_s.dack_pd = 3'h0;
		if (suspend_active) begin
			next_s.dack = 3'h0;
			if (s.rc2[RC2_DACK_LSB+:2] == DACK_TRISTATE) begin
				next_s.dack_oe = 3'h0;
			end else begin
				// Reserved codes fall back to the pull-low setting.
				next_s.dack_oe = 3'h6;
				next_s.dack_pd = 3'h1;
			end
		end

		// Normally-high processor outputs; a powered-off processor must not be back-fed.
		next_s.high    = cpu_high_in;
		next_s.high_oe = {HIGH_W{1'b1}};
		if (suspend_active && s.fc3[FC3_ZV_BIT]) begin
			next_s.high_oe = {HIGH_W{1'b0}};
		end

		// Processor resets on resume.
		next_s.susp_d   = suspend_active;
		next_s.soft_rst = soft_reset_req | (s.fc3[FC3_SRST_BIT] & rst_pulse);
		next_s.hard_rst = hard_reset_req | (s.fc3[FC3_ZV_BIT] & rst_pulse);

		// Clock gating works on the oscillator level alone, so it is blind to the 1X/2X ratio.
		next_s.periph_clk = fourteen_mhz_oscillator & s.pmu5[PMU5_PERI_BIT];
		next_s.kb_clk  = fourteen_mhz_oscillator & ~s.pmu11[PMU11_KB_BIT];
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s       <= '0;
			s.fc1   <= FC1_RST;
			s.fc3   <= FC3_RST;
			s.rc1   <= RC1_RST;
			s.rc2   <= RC2_RST;
			s.pmu5  <= PMU5_RST;
			s.pmu11 <= PMU11_RST;
		end else begin
			s <= next_s;
		end
	end

	assign avs_readdata                = {24'h000000, s.rdata};
	assign addr_pulldown_en            = s.addr_pd;
	assign data_pulldown_en            = s.data_pd;
	assign cycle_pulldown_en           = s.cyc_pd;
	assign float_error_pin_pullup_en   = s.fpe_pu;
	assign float_error_pin_pulldown_en = s.fpe_pd;
	assign dma_ack_decode_lines        = s.dack;
	assign dma_ack_decode_lines_oe     = s.dack_oe;
	assign dma_ack_decode_lines_pd     = s.dack_pd;
	assign cpu_high_out                = s.high;
	assign cpu_high_oe                 = s.high_oe;
	assign soft_cpu_reset_out          = s.soft_rst;
	assign cpu_hard_reset_out          = s.hard_rst;
	assign periph_clock_out            = s.periph_clk;
	assign keyboard_clock_out          = s.kb_clk;
	assign keyboard_clock_out_two      = s.kb_clk;

	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	auto_hold_pd_a: assert property (
		(s.fc1[FC1_AUTO_BIT] && s.rc1[RC1_ADDR_LSB+:2] == PD_AUTO
			&& s.rc1[RC1_CTRL_LSB+:2] == PD_AUTO && bus_hold)
		|=> addr_pulldown_en && cycle_pulldown_en
	) else $error("Automatic pull-down missing during bus hold.");

	auto_idle_pd_a: assert property (
		(s.rc1[RC1_DATA_LSB+:2] == PD_AUTO && !(s.fc1[FC1_AUTO_BIT] && (bus_hold || suspend_active)))
		|=> !data_pulldown_en
	) else $error("Automatic pull-down engaged outside its window.");

	always_pd_a: assert property (
		(s.rc1[RC1_ADDR_LSB+:2] == PD_ALWAYS) [*2] |=> addr_pulldown_en
	) else $error("Always-on pull-down not engaged.");

	never_pd_a: assert property (
		(s.rc1[RC1_CTRL_LSB+:2] == PD_NEVER) |=> !cycle_pulldown_en
	) else $error("Disabled pull-down engaged.");

	fpe_susp_a: assert property (
		(s.fc1[FC1_AUTO_BIT] && suspend_active)
		|=> float_error_pin_pulldown_en && !float_error_pin_pullup_en
	) else $error("Float error pin not pulled down in suspend.");

	dack_park_a: assert property (
		(suspend_active && s.rc2[RC2_DACK_LSB+:2] == DACK_TRISTATE) |=> dma_ack_decode_lines_oe == 3'h0
	) else $error("Decode lines not released in suspend.");

	zero_volt_a: assert property (
		(suspend_active && s.fc3[FC3_ZV_BIT]) |=> cpu_high_oe == {HIGH_W{1'b0}}
	) else $error("Normally-high outputs still driven in zero-volt suspend.");

	hard_reset_a: assert property (
		(resume_fire && s.fc3[FC3_ZV_BIT] && !(avs_write && s.bus_ack)) |-> ##2 cpu_hard_reset_out
	) else $error("Hard reset not asserted on zero-volt resume.");

	soft_reset_a: assert property (
		(resume_fire && s.fc3[FC3_SRST_BIT] && !(avs_write && s.bus_ack)) |-> ##2 soft_cpu_reset_out
	) else $error("Soft reset not pulsed on resume.");

	periph_stop_a: assert property (
		!s.pmu5[PMU5_PERI_BIT] |=> !periph_clock_out
	) else $error("Peripheral clock runs while gated off.");

	kb_stop_a: assert property (
		s.pmu11[PMU11_KB_BIT] |=> !keyboard_clock_out && !keyboard_clock_out_two
	) else $error("Keyboard clocks run while stopped.");

	bus_wait_a: assert property (
		(bus_req && !s.bus_ack) |-> avs_waitrequest ##1 (!bus_req || !avs_waitrequest)
	) else $error("Bus answer not given in one wait cycle.");

	dack_run_a: assert property (
		!suspend_active |=> dma_ack_decode_lines_oe == 3'h7
			&& dma_ack_decode_lines == $past(dma_ack_decode_in)
	) else $error("Decode lines not passed through while running.");

	dack_pull_a: assert property (
		(suspend_active && s.rc2[RC2_DACK_LSB+:2] != DACK_TRISTATE)
		|=> dma_ack_decode_lines_pd == 3'h1 && dma_ack_decode_lines_oe == 3'h6
			&& dma_ack_decode_lines == 3'h0
	) else $error("Decode lines not parked low in suspend.");

	fpe_run_a: assert property (
		(s.fc1[FC1_AUTO_BIT] && !suspend_active)
		|=> float_error_pin_pullup_en && !float_error_pin_pulldown_en
	) else $error("Float error pin not pulled up while running.");

	powered_high_a: assert property (
		!(suspend_active && s.fc3[FC3_ZV_BIT]) |=> cpu_high_oe == {HIGH_W{1'b1}}
	) else $error("Normally-high outputs released outside zero-volt suspend.");

	kb_run_a: assert property (
		(!s.pmu11[PMU11_KB_BIT] && fourteen_mhz_oscillator)
		|=> keyboard_clock_out && keyboard_clock_out_two
	) else $error("Keyboard clocks do not follow the oscillator.");

	hold_cover_c: cover property (s.fc1[FC1_AUTO_BIT] && bus_hold ##1 addr_pulldown_en);
	zv_cover_c: cover property (resume_fire && s.fc3[FC3_ZV_BIT]);
	dack_cover_c: cover property (suspend_active ##1 dma_ack_decode_lines_pd == 3'h1);
	kb_cover_c: cover property (s.pmu11[PMU11_KB_BIT] && !s.pmu5[PMU5_PERI_BIT]);

endmodule : spc_top

// ===== tb/spc_cpu_model.sv
// Behavioural processor side: resolves the normally-high lines and measures hard reset pulses.
`timescale 1ns/10ps
module spc_cpu_model #(
	parameter int HIGH_W = 4
) (
	// Clock and reset.
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// Lines from the block.
	input  wire logic [HIGH_W-1:0] cpu_high_out,
	input  wire logic [HIGH_W-1:0] cpu_high_oe,
	input  wire logic              cpu_hard_reset_out,
	// What the processor sees.
	output logic      [HIGH_W-1:0] cpu_high_wire,
	output int                     hard_len
);
	logic [HIGH_W-1:0] last;
	logic              prev;
	// An undriven line shows the inverse of its last level, so a float never looks correct.
	always_comb begin
		for (int i = 0; i < HIGH_W; i++) begin
			cpu_high_wire[i] = cpu_high_oe[i] ? cpu_high_out[i] : ~last[i];
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			last     <= '0;
			prev     <= 1'b0;
			hard_len <= 0;
		end else begin
			last <= cpu_high_wire;
			prev <= cpu_hard_reset_out;
			if (cpu_hard_reset_out) begin
				hard_len <= prev ? hard_len + 1 : 1;
			end
		end
	end
endmodule : spc_cpu_model

// ===== tb/spc_top_tb_top.sv
// Self-checking bench for suspend pin conditioning.
`timescale 1ns/10ps
module spc_top_tb_top;
	import spc_pkg::*;
	localparam int RC = 4;
	logic sys_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [9:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, rd;
	logic [3:0] avs_byteenable = '0, cpu_high_in = 4'hf, cpu_high_out, cpu_high_oe, wire_lvl;
	logic bus_hold = 1'b0, suspend_active = 1'b0, osc = 1'b0, avs_waitrequest;
	logic [2:0] dack_in = 3'h5, dack_lines, dack_oe, dack_pd;
	logic apd, dpd, cpd, fpu, fpd, srst, hrst, pclk, kb, kb2, pi, pk;
	int mismatches = 0, check_count = 0, oc = 0, pclk_n = 0, kb_n = 0, hard_len;
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		oc <= (oc == 6) ? 0 : oc + 1;
		if (oc == 6) osc <= ~osc;
		pi <= pclk;
		pk <= kb;
		if (pi !== pclk) pclk_n <= pclk_n + 1;
		if (pk !== kb || kb2 !== kb) kb_n <= kb_n + 1;
	end
	spc_top #(.HIGH_W(4), .RST_CYCLES(RC)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.bus_hold(bus_hold), .suspend_active(suspend_active), .addr_pulldown_en(apd),
		.data_pulldown_en(dpd), .cycle_pulldown_en(cpd), .float_error_pin_pullup_en(fpu),
		.float_error_pin_pulldown_en(fpd), .dma_ack_decode_in(dack_in),
		.dma_ack_decode_lines(dack_lines), .dma_ack_decode_lines_oe(dack_oe),
		.dma_ack_decode_lines_pd(dack_pd), .cpu_high_in(cpu_high_in),
		.cpu_high_out(cpu_high_out), .cpu_high_oe(cpu_high_oe), .soft_reset_req(1'b0),
		.hard_reset_req(1'b0), .soft_cpu_reset_out(srst), .cpu_hard_reset_out(hrst),
		.fourteen_mhz_oscillator(osc), .periph_clock_out(pclk), .keyboard_clock_out(kb),
		.keyboard_clock_out_two(kb2));
	spc_cpu_model #(.HIGH_W(4)) i_cpu (.sys_clk(sys_clk), .rst_b(rst_b),
		.cpu_high_out(cpu_high_out), .cpu_high_oe(cpu_high_oe),
		.cpu_hard_reset_out(hrst), .cpu_high_wire(wire_lvl), .hard_len(hard_len));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge sys_clk);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= {idx, 2'h0};
		avs_writedata <= {24'h0, wd};
		avs_byteenable <= 4'h1;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic pins(input logic h, input logic s);
		@(posedge sys_clk);
		bus_hold <= h;
		suspend_active <= s;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : pins
	task automatic t_reset();
		bus(1'b0, FC1_IDX, 8'h00); chk(rd, {24'h0, FC1_RST});
		bus(1'b0, FC3_IDX, 8'h00); chk(rd, {24'h0, FC3_RST});
		bus(1'b0, RC1_IDX, 8'h00); chk(rd, {24'h0, RC1_RST});
		bus(1'b0, RC2_IDX, 8'h00); chk(rd, {24'h0, RC2_RST});
		bus(1'b1, 8'hff, 8'h5a);
		bus(1'b0, 8'hff, 8'h00); chk(rd, 32'h0);
		pins(1'b1, 1'b0); chk(apd, 1'b0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_keepers();
		logic e;
		bus(1'b1, FC1_IDX, 8'h40);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, RC1_IDX, {c[1:0], c[1:0], c[1:0], 2'h0});
			bus(1'b0, RC1_IDX, 8'h00); chk(rd[7:2], {c[1:0], c[1:0], c[1:0]});
			for (int s = 0; s < 4; s++) begin
				pins(s[0], s[1]);
				e = (c == 1) || (c == 0 && s != 0);
				chk({apd, dpd, cpd}, {3{e}});
			end
		end
		$display("keeper test done");
	endtask : t_keepers
	task automatic t_fpe_dack();
		bus(1'b1, RC2_IDX, 8'h00);
		pins(1'b0, 1'b0); chk({fpu, fpd}, 2'b10);
		chk({dack_oe, dack_pd, dack_lines}, {3'b111, 3'b000, 3'b101});
		pins(1'b0, 1'b1); chk({fpu, fpd}, 2'b01);
		chk({dack_oe, dack_pd, dack_lines}, {3'b110, 3'b001, 3'b000});
		bus(1'b1, RC2_IDX, 8'h40);
		pins(1'b0, 1'b1); chk({dack_oe, dack_pd}, 6'h0);
		pins(1'b0, 1'b0);
		$display("float error and decode test done");
	endtask : t_fpe_dack
	task automatic t_zero(input logic [7:0] fc3, input int exp);
		int h, s;
		h = 0;
		s = 0;
		bus(1'b1, FC3_IDX, fc3);
		pins(1'b0, 1'b1);
		if (fc3[FC3_ZV_BIT]) chk(cpu_high_oe, 4'h0);
		else chk({cpu_high_oe, wire_lvl}, 8'hff);
		@(posedge sys_clk);
		suspend_active <= 1'b0;
		repeat (20) begin
			@(posedge sys_clk);
			#1;
			h += (hrst === 1'b1);
			s += (srst === 1'b1);
		end
		chk(h, exp);
		chk(s, fc3[FC3_SRST_BIT] ? RC : 0);
		if (exp > 0) chk(hard_len, RC);
		$display("zero volt test done");
	endtask : t_zero
	task automatic t_clocks();
		int a;
		bus(1'b1, PMU5_IDX, 8'h10);
		a = pclk_n;
		repeat (60) @(posedge sys_clk);
		chk(pclk_n > a + 2, 1'b1);
		bus(1'b1, PMU5_IDX, 8'h00);
		repeat (3) @(posedge sys_clk);
		a = pclk_n;
		repeat (60) @(posedge sys_clk);
		chk(pclk_n, a);
		a = kb_n;
		repeat (60) @(posedge sys_clk);
		chk(kb_n > a + 2, 1'b1);
		bus(1'b1, PMU11_IDX, 8'h01);
		repeat (3) @(posedge sys_clk);
		a = kb_n;
		repeat (60) @(posedge sys_clk);
		chk({kb_n == a, kb, kb2}, 3'b100);
		$display("clock gating test done");
	endtask : t_clocks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset();
		t_keepers();
		t_fpe_dack();
		t_zero(8'h00, 0);
		t_zero(8'h28, RC);
		t_clocks();
		tally_and_finish();
	end
endmodule : spc_top_tb_top
